// [logic/fgr_pkg.sv]
// Package with register map, field positions and timing constants of the fast gate block
package fgr_pkg;

   localparam logic [7:0]  FGR_PORT_ADDR     = 8'h92;
   localparam logic [7:0]  FGR_CFG_ADDR      = 8'hf0;
   localparam logic [7:0]  FGR_PORT_RESET    = 8'h24;
   localparam logic [7:0]  FGR_CFG_RESET     = 8'h00;
   localparam logic [7:0]  FGR_STATUS_RESET  = 8'h00;
   localparam logic [7:0]  FGR_READ_FIXED    = 8'h24;
   localparam logic [7:0]  FGR_READ_ZERO     = 8'h00;

   localparam int          FGR_BIT_RST       = 0;
   localparam int          FGR_BIT_A20       = 1;
   localparam int          FGR_BIT_PORT_EN   = 2;
   localparam int          FGR_BIT_POL       = 7;

   localparam int          FGR_CLK_HZ        = 125_000_000;
   localparam int          FGR_KBC_HZ        = 12_000_000;
   localparam int          FGR_REF_HZ        = 16_000_000;
   localparam int          FGR_RST_REF_CYC   = 24;
   // Longer figures win: 14 us delay covers 500 ns, 6 us low covers 1 us
   localparam int          FGR_DELAY_NS      = 14_000;
   localparam int          FGR_LOW_NS        = 6_000;
   localparam int          FGR_DELAY_CYC     = (FGR_DELAY_NS * 125 + 999) / 1000;
   localparam int          FGR_LOW_CYC       = (FGR_LOW_NS * 125 + 999) / 1000;
   localparam int          FGR_MIN_RST_CYC   =
      (FGR_RST_REF_CYC * (FGR_CLK_HZ / 1000) + FGR_REF_HZ / 1000 - 1) / (FGR_REF_HZ / 1000);
   localparam int          FGR_CNT_W         = 12;
   localparam int          FGR_ACC_W         = 8;

   typedef enum logic [1:0] {FGR_IDLE, FGR_DELAY, FGR_PULSE, FGR_HOLD} fgr_state_t;

endpackage

// [logic/fgr_kbc_clk.sv]
// Fractional divider making the 12 MHz keyboard controller enable from the system clock
`timescale 1ns/1ps
module fgr_kbc_clk
   import fgr_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst_n,
   output logic      kbc_clk_en
);

   localparam logic [FGR_ACC_W+16-1:0] STEP = (FGR_ACC_W+16)'(FGR_KBC_HZ / 1000);
   localparam logic [FGR_ACC_W+16-1:0] MODV = (FGR_ACC_W+16)'(FGR_CLK_HZ / 1000);

   logic [FGR_ACC_W+16-1:0] acc;
   wire  [FGR_ACC_W+16-1:0] sum  = acc + STEP;
   wire                     wrap = sum >= MODV;
   wire  [FGR_ACC_W+16-1:0] next_acc = wrap ? sum - MODV : sum;

   // Accumulator gives an average rate of 12 MHz
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc        <= '0;
         kbc_clk_en <= 1'b0;
      end else begin
         acc        <= next_acc;
         kbc_clk_en <= wrap;
      end
   end

endmodule

// [logic/fgr_pulse.sv]
// Delay then low pulse generator for the fast reset line
`timescale 1ns/1ps
module fgr_pulse
   import fgr_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic req_bit,
   output logic      pulse_n,
   output logic      busy
);

   fgr_state_t              state;
   fgr_state_t              next_state;
   logic [FGR_CNT_W-1:0]    cnt;
   wire                     cnt_done = cnt == '0;

   always_comb begin
      next_state = state;
      unique case (state)
         FGR_IDLE:  if (req_bit) next_state = FGR_DELAY;
         FGR_DELAY: if (cnt_done) next_state = FGR_PULSE;
         FGR_PULSE: if (cnt_done) next_state = FGR_HOLD;
         FGR_HOLD:  if (!req_bit) next_state = FGR_IDLE;
      endcase
   end

   // Counter times delay and width
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= FGR_IDLE;
         cnt   <= '0;
      end else begin
         state <= next_state;
         if (state == FGR_IDLE && req_bit)
            cnt <= FGR_CNT_W'(FGR_DELAY_CYC - 1);
         else if (state == FGR_DELAY && cnt_done)
            cnt <= FGR_CNT_W'(FGR_LOW_CYC - 1);
         else if (!cnt_done)
            cnt <= cnt - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         pulse_n <= 1'b1;
      else
         pulse_n <= !(next_state == FGR_PULSE);
   end

   assign busy = state != FGR_IDLE;

endmodule

// [logic/fgr_top.sv]
// Fast A20 gate and fast CPU reset block with its control port
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module fgr_top
   import fgr_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   input  wire logic       kbc_a20_port_bit,
   input  wire logic       kbc_cpu_reset_n,
   input  wire logic       cpu_reset_in,
   input  wire logic [3:0] kbc_line_drive,
   input  wire logic [7:0] kbc_status_wdata,
   input  wire logic       kbc_status_we,
   output logic [7:0]      host_status,
   output logic            kbc_clk_en,
   output logic            kbd_clock_line,
   output logic            kbd_data_line,
   output logic            mouse_clock_line,
   output logic            mouse_data_line,
   output logic            fast_a20_level,
   output logic            fast_cpu_reset_n,
   output logic            a20_mask_n_out,
   output logic            combined_cpu_reset_out,
   output logic            fast_pulse_busy
);

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] kbd_reset_gate_config;
   logic       fast_rst_bit;
   logic [7:0] next_rdata;

   wire port_en  = kbd_reset_gate_config[FGR_BIT_PORT_EN];
   wire hit_port = port_en && (reg_addr == FGR_PORT_ADDR);
   wire hit_cfg  = reg_addr == FGR_CFG_ADDR;
   wire wr_port  = reg_wr && hit_port;
   wire wr_cfg   = reg_wr && hit_cfg;

   wire [7:0] port_view = FGR_READ_FIXED
                        | (8'(fast_a20_level) << FGR_BIT_A20)
                        | (8'(fast_rst_bit) << FGR_BIT_RST);

   assign next_rdata = hit_port ? port_view :
                       hit_cfg  ? kbd_reset_gate_config : FGR_READ_ZERO;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         kbd_reset_gate_config <= FGR_CFG_RESET;
         fast_a20_level        <= 1'b0;
         fast_rst_bit          <= 1'b0;
         reg_rdata             <= FGR_READ_ZERO;
      end else begin
         if (wr_cfg)
            kbd_reset_gate_config <= reg_wdata;
         if (wr_port) begin
            fast_a20_level <= reg_wdata[FGR_BIT_A20];
            fast_rst_bit   <= reg_wdata[FGR_BIT_RST];
         end
         reg_rdata <= reg_rd ? next_rdata : FGR_READ_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Host status register, cleared by reset, written by controller
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         host_status <= FGR_STATUS_RESET;
      else if (kbc_status_we)
         host_status <= kbc_status_wdata;
   end

   // Keyboard and mouse lines held low through reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         kbd_clock_line   <= 1'b0;
         kbd_data_line    <= 1'b0;
         mouse_clock_line <= 1'b0;
         mouse_data_line  <= 1'b0;
      end else begin
         kbd_clock_line   <= kbc_line_drive[0];
         kbd_data_line    <= kbc_line_drive[1];
         mouse_clock_line <= kbc_line_drive[2];
         mouse_data_line  <= kbc_line_drive[3];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   fgr_kbc_clk u_kbc_clk (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .kbc_clk_en (kbc_clk_en)
   );

   fgr_pulse u_pulse (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .req_bit (fast_rst_bit),
      .pulse_n (fast_cpu_reset_n),
      .busy    (fast_pulse_busy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Both paths merge; fast path counted only while enabled
   wire merged_rst_n = kbc_cpu_reset_n & (fast_cpu_reset_n | ~port_en);
   wire out_pol      = kbd_reset_gate_config[FGR_BIT_POL];

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         combined_cpu_reset_out <= 1'b1;
         a20_mask_n_out         <= 1'b0;
      end else begin
         combined_cpu_reset_out <= merged_rst_n ^ out_pol;
         a20_mask_n_out <= kbc_a20_port_bit | fast_a20_level | cpu_reset_in;
      end
   end

endmodule

// [bench/fgr_props.sv]
// Checker for the fast gate block ports
`timescale 1ns/1ps
module fgr_props
   import fgr_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       kbc_a20_port_bit,
   input wire logic       kbc_cpu_reset_n,
   input wire logic       cpu_reset_in,
   input wire logic       fast_a20_level,
   input wire logic       fast_cpu_reset_n,
   input wire logic       a20_mask_n_out,
   input wire logic       combined_cpu_reset_out,
   input wire logic       fast_pulse_busy
);
   logic [7:0]  cfg;
   logic [11:0] lo_n;
   logic [11:0] dl_n;
   wire         en = cfg[FGR_BIT_PORT_EN];
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg  <= 8'h00;
         lo_n <= 12'h000;
         dl_n <= 12'h000;
      end else begin
         if (reg_wr && reg_addr == FGR_CFG_ADDR) cfg <= reg_wdata;
         lo_n <= fast_cpu_reset_n ? 12'h000 : lo_n + 12'h001;
         dl_n <= (fast_pulse_busy && fast_cpu_reset_n) ? dl_n + 12'h001 : 12'h000;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_port_wr;
      reg_wr && reg_addr == FGR_PORT_ADDR && en;
   endsequence
   sequence s_port_rd;
      reg_rd && reg_addr == FGR_PORT_ADDR && en;
   endsequence
   a_mask_or: assert property (
      $past(rst_n) |-> a20_mask_n_out == $past(kbc_a20_port_bit | fast_a20_level | cpu_reset_in))
      else $error("a20 mask wrong");
   a_reset_and: assert property (
      $past(rst_n) |-> combined_cpu_reset_out ==
      $past((kbc_cpu_reset_n & (fast_cpu_reset_n | ~en)) ^ cfg[FGR_BIT_POL]))
      else $error("combined reset wrong");
   a_port_read: assert property (s_port_rd ##1 1'b1 |->
      reg_rdata[7:1] == {6'h09, $past(fast_a20_level)}) else $error("port read wrong");
   a_read_zero: assert property (
      $past(!(reg_rd && (reg_addr == FGR_CFG_ADDR || (reg_addr == FGR_PORT_ADDR && en))))
      |-> reg_rdata == 8'h00) else $error("read data not zero");
   a_a20_write: assert property (s_port_wr |=>
      fast_a20_level == $past(reg_wdata[FGR_BIT_A20])) else $error("a20 level wrong");
   a_low_width: assert property ($rose(fast_cpu_reset_n) |-> lo_n == FGR_LOW_CYC)
      else $error("pulse width wrong");
   a_delay_len: assert property ($fell(fast_cpu_reset_n) |->
      dl_n >= FGR_DELAY_CYC - 2 && dl_n <= FGR_DELAY_CYC + 4) else $error("delay wrong");
   a_idle_high: assert property (!fast_pulse_busy |-> fast_cpu_reset_n)
      else $error("reset low while idle");
endmodule
bind fgr_top fgr_props u_props (.*);

// [bench/fgr_cpu_model.sv]
// Host processor model counting reset pulses and watching the A20 mask
`timescale 1ns/1ps
module fgr_cpu_model (
   input  wire logic sys_clk,
   input  wire logic a20_mask_n_out,
   input  wire logic combined_cpu_reset_out,
   output int        n_resets,
   output logic      a20_masked
);
   logic rst_d;
   initial n_resets = 0;
   always @(posedge sys_clk) begin
      rst_d <= combined_cpu_reset_out;
      if (rst_d && !combined_cpu_reset_out) n_resets <= n_resets + 1;
   end
   assign a20_masked = !a20_mask_n_out;
endmodule

// [bench/tb_fast_gate_a20_and_cpu_reset.sv]
// Testbench for the fast gate block
`timescale 1ns/1ps
module tb_fast_gate_a20_and_cpu_reset;
   import fgr_pkg::*;
   logic       sys_clk = '0, rst_n = '0, reg_wr = '0, reg_rd = '0, kbc_status_we = '0;
   logic       kbc_a20_port_bit = '0, kbc_cpu_reset_n = '1, cpu_reset_in = '0;
   logic [7:0] reg_addr = '0, reg_wdata = '0, kbc_status_wdata = '0, reg_rdata, host_status, rdv;
   logic [3:0] kbc_line_drive = '0;
   logic       kbc_clk_en, kbd_clock_line, kbd_data_line, mouse_clock_line, mouse_data_line;
   logic       fast_a20_level, fast_cpu_reset_n, a20_mask_n_out, combined_cpu_reset_out;
   logic       fast_pulse_busy, a20_masked;
   int         n_errors = 0, num_checks = 0, i, k, n_resets;
   wire [3:0]  lines = {mouse_data_line, mouse_clock_line, kbd_data_line, kbd_clock_line};
   always #4 sys_clk = ~sys_clk;
   fgr_top u_dut (.*);
   fgr_cpu_model u_cpu (.*);
   task chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One bus cycle, read data captured in the following cycle
   task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1 rdv = reg_rdata;
      @(posedge sys_clk);
      #1;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task wt(input logic lvl);
      for (i = 0; i < 3000 && fast_cpu_reset_n !== lvl; i++) #8;
      if (i == 3000) begin
         n_errors++;
         report_and_stop;
      end
   endtask
   initial begin
      cyc(1);
      chk("reset", {fast_a20_level, fast_cpu_reset_n, lines, host_status}, 14'h1000);
      cyc(190);
      rst_n <= 1'b1;
      acc(1'b1, FGR_PORT_ADDR, 8'h03);
      acc(1'b0, FGR_PORT_ADDR, 8'h00);
      chk("locked", {rdv, fast_a20_level, fast_pulse_busy}, 16'h0000);
      acc(1'b1, FGR_CFG_ADDR, 8'h04);
      acc(1'b0, 8'h55, 8'h00);
      chk("unmapped", rdv, 16'h0000);
      for (k = 0; k < 8; k++) begin
         acc(1'b1, FGR_PORT_ADDR, {6'h00, k[0], 1'b0});
         kbc_a20_port_bit <= k[1];
         cpu_reset_in <= k[2];
         acc(1'b0, FGR_PORT_ADDR, 8'h00);
         chk("port", rdv, FGR_READ_FIXED | {k[0], 1'b0});
         chk("mask", {a20_mask_n_out, a20_masked}, {|k[2:0], k[2:0] == 0});
      end
      acc(1'b1, FGR_PORT_ADDR, 8'h01);
      wt(1'b0);
      chk("delay", 16'(i + 2 >= FGR_DELAY_CYC && i < FGR_DELAY_CYC + 4), 16'h1);
      cyc(2);
      chk("merged", combined_cpu_reset_out, 16'h0);
      wt(1'b1);
      chk("width", 16'(i + 2 >= FGR_LOW_CYC && i < FGR_LOW_CYC + 2), 16'h1);
      acc(1'b1, FGR_PORT_ADDR, 8'h01);
      cyc(2600);
      chk("no rearm", 16'(n_resets), 16'h1);
      acc(1'b1, FGR_PORT_ADDR, 8'h00);
      acc(1'b1, FGR_PORT_ADDR, 8'h01);
      wt(1'b0);
      wt(1'b1);
      cyc(2);
      chk("rearm", 16'(n_resets), 16'h2);
      acc(1'b1, FGR_CFG_ADDR, 8'h80);
      kbc_cpu_reset_n <= 1'b0;
      cyc(2);
      chk("pol low", combined_cpu_reset_out, 16'h1);
      kbc_cpu_reset_n <= 1'b1;
      kbc_line_drive <= 4'ha;
      kbc_status_wdata <= 8'h5a;
      kbc_status_we <= 1'b1;
      cyc(1);
      kbc_status_we <= 1'b0;
      cyc(1);
      chk("pol high", {combined_cpu_reset_out, lines, host_status}, 16'h0a5a);
      k = 0;
      repeat (125) begin
         @(posedge sys_clk);
         #1 k += kbc_clk_en;
      end
      chk("clk en", 16'(k), 16'd12);
      acc(1'b1, FGR_CFG_ADDR, 8'h04);
      acc(1'b1, FGR_PORT_ADDR, 8'h03);
      rst_n <= 1'b0;
      cyc(2);
      chk("rerst", {fast_a20_level, fast_cpu_reset_n, lines, host_status}, 14'h1000);
      cyc(188);
      rst_n <= 1'b1;
      acc(1'b1, FGR_CFG_ADDR, 8'h04);
      acc(1'b0, FGR_PORT_ADDR, 8'h00);
      chk("cleared", rdv, FGR_PORT_RESET);
      report_and_stop;
   end
endmodule
